/* File: rtl/dpmx_defs.svh */
// Purpose: timing and address constants for the dual-port mailbox host
// Assumes: 100 MHz clock
// Notes:   counts derived from nanosecond figures, least times round up
`ifndef DPMX_DEFS_SVH
`define DPMX_DEFS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define DPMX_CLK_NS        10
`define DPMX_SETTLE_NS     50
`define DPMX_PULSE_NS      40
`define DPMX_ACCESS_NS     60
`define DPMX_SYNC_CYC      4
`define DPMX_CYC(ns)       (((ns) + `DPMX_CLK_NS - 1) / `DPMX_CLK_NS)
`define DPMX_SETTLE_CYC    (`DPMX_CYC(`DPMX_SETTLE_NS) + `DPMX_SYNC_CYC)
`define DPMX_PULSE_CYC     `DPMX_CYC(`DPMX_PULSE_NS)
`define DPMX_READ_CYC      (`DPMX_CYC(`DPMX_ACCESS_NS) + `DPMX_SYNC_CYC)

// ----------------------------------------------------------------------
// addresses and widths
// ----------------------------------------------------------------------
`define DPMX_ADDR_W        15
`define DPMX_DATA_W        16
`define DPMX_MBOX_LEFT     15'h7ffe
`define DPMX_MBOX_RIGHT    15'h7fff
`define DPMX_SEM_COUNT     8
`define DPMX_SEM_LAST      3'h7
`define DPMX_CNT_W         8

`endif

/* File: rtl/dpmx_pkg.sv */
// Purpose: types shared by the dual-port mailbox host
// Assumes: nothing
// Notes:   constants live in dpmx_defs.svh
package dpmx_pkg;

    // ------------------------------------------------------------------
    // user commands
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_RD,
        OP_WR,
        OP_SEM_REQ,
        OP_SEM_REL,
        OP_SEM_RD
    } dpmx_op_t;

    // ------------------------------------------------------------------
    // access sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE,
        ST_READ,
        ST_DONE
    } dpmx_state_t;

endpackage : dpmx_pkg

/* File: rtl/dpmx_sync.sv */
// Purpose: three-stage pin synchroniser, change taken when stages 2 and 3 agree
// Assumes: single clock domain on the receiving side
// Notes:   stage 1 feeds stage 2 only
`timescale 1ns/1ps
`default_nettype none

module dpmx_sync #(
    parameter int          W     = 1,
    parameter logic [W-1:0] RST_V = '0
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // pin side and filtered side
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ------------------------------------------------------------------
    // per-bit synchroniser
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            // three flops, output moves only on agreement
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_q     <= RST_V[gi];
                    s2_q     <= RST_V[gi];
                    s3_q     <= RST_V[gi];
                    q[gi]    <= RST_V[gi];
                end else begin
                    s1_q <= d[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        q[gi] <= s3_q;
                    end
                end
            end
        end
    endgenerate

endmodule : dpmx_sync

`default_nettype wire

/* File: rtl/dpmx_host.sv */
// Purpose: host controller driving one port of a dual-port RAM with mailbox,
//          conflict flag and semaphores
// Assumes: one port per instance, 100 MHz clock, all pin inputs asynchronous
// Notes:   semaphores are freed after reset before commands are taken
//
// Summary of operation
// - right processor reads 7FFF to clear right flag.
// - host holds slave conflict input high, or low to block writes.
// - only one master arbitrates; slaves use its flag as inhibit.
// - host holds address and select until flag resolves, then pulses write.
//   here: flag sampled once after settle; if busy, no pulse, rsp_inhibited set.
// - at power-up, host writes one to every semaphore.
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defs.svh"

module dpmx_host #(
    parameter bit IS_LEFT     = 1'b1,
    parameter bit DRIVE_SLAVE = 1'b0
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // user command port
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire dpmx_pkg::dpmx_op_t       cmd_op,
    input  wire logic [`DPMX_ADDR_W-1:0]  cmd_addr,
    input  wire logic [`DPMX_DATA_W-1:0]  cmd_wdata,
    // user answer port
    output logic                          rsp_valid,
    output logic [`DPMX_DATA_W-1:0]       rsp_rdata,
    output logic                          rsp_inhibited,
    // user status and control
    output logic                          mbox_pending,
    output logic                          init_busy,
    input  wire logic                     block_writes,
    // ram port pins
    output logic [`DPMX_ADDR_W-1:0]       addr,
    output logic                          port_select_low_active_n,
    output logic                          port_select_high_active,
    output logic                          token_space_select_n,
    output logic                          write_strobe_n,
    output logic                          drive_enable_n,
    output logic                          upper_byte_n,
    output logic                          lower_byte_n,
    // data pins, three-signal form
    input  wire logic [`DPMX_DATA_W-1:0]  data_i,
    output logic [`DPMX_DATA_W-1:0]       data_o,
    output logic                          data_oe_n,
    // conflict flag pin, three-signal form
    input  wire logic                     conflict_flag_n_i,
    output logic                          conflict_flag_n_o,
    output logic                          conflict_flag_oe_n,
    // mailbox flag pin
    input  wire logic                     mailbox_flag_n
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [`DPMX_DATA_W-1:0] data_s;
    logic                    conflict_n_s;
    logic                    mailbox_n_s;

    dpmx_sync #(
        .W     (`DPMX_DATA_W + 2),
        .RST_V ({{`DPMX_DATA_W{1'b0}}, 2'b11})
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .d       ({data_i, conflict_flag_n_i, mailbox_flag_n}),
        .q       ({data_s, conflict_n_s, mailbox_n_s})
    );

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    dpmx_pkg::dpmx_state_t   state_q;
    logic [`DPMX_CNT_W-1:0]  cnt_q;
    logic [`DPMX_ADDR_W-1:0] addr_q;
    logic [`DPMX_DATA_W-1:0] wdata_q;
    logic                    is_wr_q;
    logic                    is_sem_q;
    logic                    init_q;
    logic [2:0]              sem_idx_q;

    assign cmd_ready = (state_q == dpmx_pkg::ST_IDLE) && !init_q;
    assign init_busy = init_q;

    // state, counter and latched request
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q       <= dpmx_pkg::ST_IDLE;
            cnt_q         <= '0;
            addr_q        <= '0;
            wdata_q       <= '0;
            is_wr_q       <= 1'b0;
            is_sem_q      <= 1'b0;
            init_q        <= 1'b1;
            sem_idx_q     <= '0;
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
            rsp_inhibited <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_q)
                dpmx_pkg::ST_IDLE: begin
                    if (init_q) begin
                        addr_q   <= {{(`DPMX_ADDR_W-3){1'b0}}, sem_idx_q};
                        wdata_q  <= {{(`DPMX_DATA_W-1){1'b0}}, 1'b1};
                        is_wr_q  <= 1'b1;
                        is_sem_q <= 1'b1;
                        cnt_q    <= `DPMX_CNT_W'(`DPMX_SETTLE_CYC);
                        state_q  <= dpmx_pkg::ST_SETUP;
                    end else if (cmd_valid) begin
                        addr_q   <= cmd_addr;
                        is_sem_q <= (cmd_op != dpmx_pkg::OP_RD) &&
                                    (cmd_op != dpmx_pkg::OP_WR);
                        is_wr_q  <= (cmd_op == dpmx_pkg::OP_WR) ||
                                    (cmd_op == dpmx_pkg::OP_SEM_REQ) ||
                                    (cmd_op == dpmx_pkg::OP_SEM_REL);
                        // semaphore writes carry only bit 0
                        case (cmd_op)
                            dpmx_pkg::OP_SEM_REQ: wdata_q <= '0;
                            dpmx_pkg::OP_SEM_REL: wdata_q <= {{(`DPMX_DATA_W-1){1'b0}}, 1'b1};
                            default:              wdata_q <= cmd_wdata;
                        endcase
                        if ((cmd_op == dpmx_pkg::OP_RD) || (cmd_op == dpmx_pkg::OP_SEM_RD)) begin
                            cnt_q   <= `DPMX_CNT_W'(`DPMX_READ_CYC);
                            state_q <= dpmx_pkg::ST_READ;
                        end else begin
                            cnt_q   <= `DPMX_CNT_W'(`DPMX_SETTLE_CYC);
                            state_q <= dpmx_pkg::ST_SETUP;
                        end
                    end
                end
                dpmx_pkg::ST_SETUP: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (!is_sem_q && !conflict_n_s) begin
                        rsp_inhibited <= 1'b1;
                        state_q       <= dpmx_pkg::ST_DONE;
                    end else begin
                        rsp_inhibited <= 1'b0;
                        cnt_q         <= `DPMX_CNT_W'(`DPMX_PULSE_CYC);
                        state_q       <= dpmx_pkg::ST_PULSE;
                    end
                end
                dpmx_pkg::ST_PULSE: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= dpmx_pkg::ST_DONE;
                    end
                end
                dpmx_pkg::ST_READ: begin
                    // mailbox word read clears its flag
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        rsp_rdata     <= data_s;
                        rsp_inhibited <= 1'b0;
                        state_q       <= dpmx_pkg::ST_DONE;
                    end
                end
                dpmx_pkg::ST_DONE: begin
                    // bus idles one cycle so a latched semaphore read releases
                    state_q <= dpmx_pkg::ST_IDLE;
                    if (init_q) begin
                        sem_idx_q <= sem_idx_q + 3'h1;
                        if (sem_idx_q == `DPMX_SEM_LAST) begin
                            init_q <= 1'b0;
                        end
                    end else begin
                        rsp_valid <= 1'b1;
                    end
                end
                default: begin
                    state_q <= dpmx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drivers, registered from sequencer state
    // ------------------------------------------------------------------
    logic active;
    assign active = (state_q == dpmx_pkg::ST_SETUP) ||
                    (state_q == dpmx_pkg::ST_PULSE) ||
                    (state_q == dpmx_pkg::ST_READ);

    // address, selects, strobes and data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            addr                     <= '0;
            port_select_low_active_n <= 1'b1;
            port_select_high_active  <= 1'b0;
            token_space_select_n     <= 1'b1;
            write_strobe_n           <= 1'b1;
            drive_enable_n           <= 1'b1;
            upper_byte_n             <= 1'b1;
            lower_byte_n             <= 1'b1;
            data_o                   <= '0;
            data_oe_n                <= 1'b1;
        end else begin
            addr                     <= addr_q;
            port_select_low_active_n <= !(active && !is_sem_q);
            port_select_high_active  <= active && !is_sem_q;
            token_space_select_n     <= !(active && is_sem_q);
            write_strobe_n           <= !(state_q == dpmx_pkg::ST_PULSE);
            drive_enable_n           <= !(state_q == dpmx_pkg::ST_READ);
            upper_byte_n             <= !(active && !is_sem_q);
            lower_byte_n             <= !(active && !is_sem_q);
            data_o                   <= wdata_q;
            data_oe_n                <= !(active && is_wr_q);
        end
    end

    // ------------------------------------------------------------------
    // conflict flag drive and mailbox status
    // ------------------------------------------------------------------
    // hold slave inhibit high, low while block_writes is set
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            conflict_flag_n_o  <= 1'b1;
            conflict_flag_oe_n <= 1'b1;
        end else begin
            conflict_flag_n_o  <= !block_writes;
            conflict_flag_oe_n <= !DRIVE_SLAVE;  // driven only when DRIVE_SLAVE is set; master leaves it off
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mbox_pending <= 1'b0;
        end else begin
            mbox_pending <= !mailbox_n_s;
        end
    end

endmodule : dpmx_host

`default_nettype wire

/* File: test/dpmx_host_sva.sv */
// Purpose: port checker for the dual-port host
// Assumes: one clock, reset active high
// Notes:   bound to every dpmx_host instance
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defs.svh"
module dpmx_host_chk (
    // clock and reset
    input wire logic                    clock,
    input wire logic                    sys_rst,
    // user side
    input wire logic                    cmd_ready,
    input wire logic                    init_busy,
    input wire logic                    mbox_pending,
    // pins
    input wire logic [`DPMX_ADDR_W-1:0] addr,
    input wire logic                    port_select_low_active_n,
    input wire logic                    token_space_select_n,
    input wire logic                    write_strobe_n,
    input wire logic                    upper_byte_n,
    input wire logic                    lower_byte_n,
    input wire logic [`DPMX_DATA_W-1:0] data_o,
    input wire logic                    data_oe_n,
    input wire logic                    conflict_flag_n_i,
    input wire logic                    mailbox_flag_n
);
    logic       acc_sel;
    logic [3:0] init_wr_q;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // any select active
    assign acc_sel = !port_select_low_active_n || !token_space_select_n;
    // counts token writes done before commands open
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            init_wr_q <= 4'h0;
        end else if (init_busy && !token_space_select_n && $fell(write_strobe_n)) begin
            init_wr_q <= init_wr_q + 4'h1;
        end
    end
    a_sel_exclusive: assert property (
        !(!port_select_low_active_n && !token_space_select_n)) else $error("both spaces selected");
    a_write_hold: assert property (
        !write_strobe_n && !$past(write_strobe_n) |-> $stable(addr) && $stable(data_o))
        else $error("address or data moved in pulse");
    a_strobe_settle: assert property (
        $fell(write_strobe_n) |-> $past(acc_sel, 8)) else $error("pulse before settle");
    a_inhibit_write: assert property (
        (!conflict_flag_n_i) [*8] ##0 !port_select_low_active_n |-> !$fell(write_strobe_n))
        else $error("write while busy");
    a_drive_write: assert property (
        !write_strobe_n |-> !data_oe_n) else $error("pulse without data");
    a_byte_lanes: assert property (
        upper_byte_n == port_select_low_active_n && lower_byte_n == port_select_low_active_n)
        else $error("byte lanes differ from array select");
    a_ready_init: assert property (
        init_busy |-> !cmd_ready) else $error("ready during init");
    a_init_count: assert property (
        $fell(init_busy) |-> init_wr_q == 4'h8) else $error("init write count");
    a_mbox_track: assert property (
        $fell(mailbox_flag_n) |-> ##[2:6] mbox_pending) else $error("mailbox not seen");
endmodule : dpmx_host_chk
bind dpmx_host dpmx_host_chk i_chk (
    .clock(clock), .sys_rst(sys_rst), .cmd_ready(cmd_ready), .init_busy(init_busy),
    .mbox_pending(mbox_pending), .addr(addr), .token_space_select_n(token_space_select_n),
    .port_select_low_active_n(port_select_low_active_n), .write_strobe_n(write_strobe_n),
    .data_o(data_o), .data_oe_n(data_oe_n), .conflict_flag_n_i(conflict_flag_n_i),
    .mailbox_flag_n(mailbox_flag_n), .upper_byte_n(upper_byte_n),
    .lower_byte_n(lower_byte_n)
);
`default_nettype wire

/* File: test/dpmx_dev_model.sv */
// Purpose: behavioural dual-port device, host on the left port
// Assumes: master role, bench drives the right port
// Notes:   right port settles first, so it wins a clash
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defs.svh"
module dpmx_dev_model (
    // clock and left port
    input wire logic        clock,
    input wire logic [14:0] a,
    input wire logic        cs_n,
    input wire logic        cs,
    input wire logic        sm_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic [15:0] hd,
    input wire logic        hoe_n,
    output logic     [15:0] dq,
    output logic            bsy_n,
    output logic            int_n,
    // right port from bench
    input wire logic        r_sel,
    input wire logic        r_sem,
    input wire logic        r_we,
    input wire logic [14:0] r_a,
    input wire logic [15:0] r_d,
    output logic            r_tok_n,
    output logic            r_int
);
    logic [15:0] mem [0:32767];
    logic [15:0] drv = 16'h5a5a;
    logic [7:0]  lreq = 8'hf0, rreq = 8'h0f, own_l = 8'h0f, own_r = 8'hf0;
    logic        lat = 1'b0, lbit = 1'b1, lflag = 1'b0, rflag = 1'b0, sel;
    // master role, busy only on address match with both selected
    assign sel = !cs_n && cs;
    assign bsy_n = !(sel && r_sel && a == r_a);
    // host drives or device drives, else a changing pattern
    assign dq = hoe_n ? drv : hd;
    assign int_n = !lflag;
    assign r_int = rflag;
    assign r_tok_n = !own_r[r_a[2:0]];
    // token hand-over, left wins a tie
    task automatic settle(input logic [2:0] i);
        if (own_l[i] && lreq[i]) own_l[i] = 1'b0;
        if (own_r[i] && rreq[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i] && !lreq[i]) own_l[i] = 1'b1;
        if (!own_l[i] && !own_r[i] && !rreq[i]) own_r[i] = 1'b1;
    endtask : settle
    // array, mailbox and token activity of both ports
    always @(posedge clock) begin
        // left-port writes and flags gated by busy
        if (sel && !we_n && bsy_n) mem[a] = hd;
        // right read of its mailbox word clears its flag
        if (r_sel && !r_we && !r_sem && r_a == `DPMX_MBOX_RIGHT) rflag <= 1'b0;
        if (sel && !we_n && bsy_n && a == `DPMX_MBOX_RIGHT) rflag <= 1'b1;
        if (sel && !oe_n && bsy_n && a == `DPMX_MBOX_LEFT) lflag <= 1'b0;
        if (r_we && !r_sem) mem[r_a] = r_d;
        if (r_we && !r_sem && r_a == `DPMX_MBOX_LEFT) lflag <= 1'b1;
        // only bit 0 and the low three address bits count
        if (!sm_n && !we_n) lreq[a[2:0]] = hd[0];
        if (r_we && r_sem) rreq[r_a[2:0]] = r_d[0];
        for (int i = 0; i < 8; i++) settle(3'(i));
        // read value frozen while select and enable stay low
        if (sm_n || oe_n) lat = 1'b0;
        else if (!lat) lbit = !own_l[a[2:0]];
        if (!sm_n && !oe_n) lat = 1'b1;
        if (sel && !oe_n) drv <= mem[a];
        else if (!sm_n && !oe_n) drv <= {16{lbit}};
        else drv <= ~drv;
    end
endmodule : dpmx_dev_model
`default_nettype wire

/* File: test/dpmx_host_test.sv */
// Purpose: self-checking bench for the dual-port host
// Assumes: host on the left port of the device model
// Notes:   bench plays the right port processor
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defs.svh"
module dpmx_host_test;
    logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, block_writes = 1'b0;
    dpmx_pkg::dpmx_op_t cmd_op = dpmx_pkg::OP_RD;
    logic [14:0] cmd_addr = 15'h0000, r_a = 15'h0000, a;
    logic [15:0] cmd_wdata = 16'h0000, r_d = 16'h0000, rd, rsp_rdata, dq, hd;
    logic r_sel = 1'b0, r_sem = 1'b0, r_we = 1'b0, inh, cmd_ready, rsp_valid, rsp_inhibited;
    logic mbox_pending, init_busy, cs_n, cs, sm_n, we_n, oe_n, hoe_n, cf_i, cf_o, cf_oe_n;
    logic bsy_n, int_n, r_tok_n, r_int;
    int err_count = 0, num_checks = 0;
    dpmx_host i_dut (
        .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_inhibited(rsp_inhibited), .mbox_pending(mbox_pending),
        .init_busy(init_busy), .block_writes(block_writes), .addr(a),
        .port_select_low_active_n(cs_n), .port_select_high_active(cs),
        .token_space_select_n(sm_n), .write_strobe_n(we_n), .drive_enable_n(oe_n),
        .upper_byte_n(), .lower_byte_n(), .data_i(dq), .data_o(hd), .data_oe_n(hoe_n),
        .conflict_flag_n_i(cf_i), .conflict_flag_n_o(cf_o), .conflict_flag_oe_n(cf_oe_n),
        .mailbox_flag_n(int_n)
    );
    dpmx_dev_model i_dev (
        .clock(clock), .a(a), .cs_n(cs_n), .cs(cs), .sm_n(sm_n), .we_n(we_n), .oe_n(oe_n),
        .hd(hd), .hoe_n(hoe_n), .dq(dq), .bsy_n(bsy_n), .int_n(int_n), .r_sel(r_sel),
        .r_sem(r_sem), .r_we(r_we), .r_a(r_a), .r_d(r_d), .r_tok_n(r_tok_n), .r_int(r_int)
    );
    // flag wire: device drives unless the host enables its driver
    assign cf_i = cf_oe_n ? bsy_n : cf_o;
    always #5 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // one user command, answer kept in rd and inh
    task automatic cmd(input dpmx_pkg::dpmx_op_t op, input logic [14:0] ad);
        int n;
        @(posedge clock);
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_wdata <= {ad[7:0], 8'h5c};
        cmd_valid <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(negedge clock);
            if (cmd_ready === 1'b1) break;
        end
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (n = n; n < 500; n++) begin
            @(negedge clock);
            if (rsp_valid === 1'b1) break;
        end
        rd = rsp_rdata;
        inh = rsp_inhibited;
        if (n >= 500) begin
            err_count++;
            $display("Error at %0t: no answer", $time);
            results();
        end
    endtask : cmd
    // right port write, array or token space
    task automatic rwrite(input logic token_space_select, input logic [14:0] ad, input logic [15:0] wd);
        @(posedge clock);
        r_sem <= token_space_select;
        r_sel <= !token_space_select;
        r_a <= ad;
        r_d <= wd;
        r_we <= 1'b1;
        @(posedge clock);
        r_we <= 1'b0;
        r_sel <= 1'b0;
        r_sem <= 1'b0;
        @(negedge clock);
    endtask : rwrite
    task automatic rsel(input logic on, input logic [14:0] ad);
        @(posedge clock);
        r_sel <= on;
        r_a <= ad;
    endtask : rsel
    task automatic scen_array();
        rsel(1'b1, 15'h7000);
        cmd(dpmx_pkg::OP_WR, 15'h0020);
        check({15'h0000, inh}, 16'h0000);
        cmd(dpmx_pkg::OP_WR, `DPMX_MBOX_RIGHT);
        check({15'h0000, r_int}, 16'h0001);
        cmd(dpmx_pkg::OP_RD, 15'h0020);
        check(rd, 16'h205c);
        cmd(dpmx_pkg::OP_RD, `DPMX_MBOX_RIGHT);
        check(rd, 16'hff5c);
        rsel(1'b1, `DPMX_MBOX_RIGHT);
        repeat (2) @(negedge clock);
        check({15'h0000, r_int}, 16'h0000);
        rsel(1'b0, 15'h0000);
    endtask : scen_array
    task automatic scen_mbox();
        rwrite(1'b0, `DPMX_MBOX_LEFT, 16'h2468);
        repeat (6) @(negedge clock);
        check({15'h0000, mbox_pending}, 16'h0001);
        rsel(1'b1, `DPMX_MBOX_LEFT);
        cmd(dpmx_pkg::OP_RD, `DPMX_MBOX_LEFT);
        repeat (6) @(negedge clock);
        check({15'h0000, mbox_pending}, 16'h0001);
        rsel(1'b0, 15'h0000);
        cmd(dpmx_pkg::OP_RD, `DPMX_MBOX_LEFT);
        check(rd, 16'h2468);
        repeat (6) @(negedge clock);
        check({15'h0000, mbox_pending}, 16'h0000);
    endtask : scen_mbox
    task automatic scen_sem();
        cmd(dpmx_pkg::OP_SEM_RD, 15'h0005);
        check(rd, 16'hffff);
        cmd(dpmx_pkg::OP_SEM_REQ, 15'h7ffb);
        cmd(dpmx_pkg::OP_SEM_RD, 15'h0003);
        check(rd, 16'h0000);
        rwrite(1'b1, 15'h0003, 16'h0000);
        check({15'h0000, r_tok_n}, 16'h0001);
        cmd(dpmx_pkg::OP_SEM_RD, 15'h0003);
        check(rd, 16'h0000);
        cmd(dpmx_pkg::OP_SEM_REL, 15'h0003);
        check({15'h0000, r_tok_n}, 16'h0000);
        cmd(dpmx_pkg::OP_SEM_RD, 15'h0003);
        check(rd, 16'hffff);
        rwrite(1'b1, 15'h0003, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            cmd(dpmx_pkg::OP_SEM_REQ, 15'(i));
            cmd(dpmx_pkg::OP_SEM_RD, 15'(i));
            check(rd, 16'h0000);
            cmd(dpmx_pkg::OP_SEM_REL, 15'(i));
            cmd(dpmx_pkg::OP_SEM_RD, 15'(i));
            check(rd, 16'hffff);
        end
    endtask : scen_sem
    task automatic scen_conflict();
        rwrite(1'b0, 15'h0020, 16'h0bad);
        rsel(1'b1, 15'h0020);
        cmd(dpmx_pkg::OP_WR, 15'h0020);
        check({15'h0000, inh}, 16'h0001);
        rsel(1'b0, 15'h0000);
        cmd(dpmx_pkg::OP_RD, 15'h0020);
        check(rd, 16'h0bad);
        @(posedge clock);
        block_writes <= 1'b1;
        repeat (4) @(negedge clock);
        check({14'h0000, cf_o, cf_oe_n}, 16'h0001);
        @(posedge clock);
        block_writes <= 1'b0;
        repeat (4) @(negedge clock);
        check({14'h0000, cf_o, cf_oe_n}, 16'h0003);
    endtask : scen_conflict
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        // right side frees every token latch too
        for (int i = 0; i < 8; i++) rwrite(1'b1, 15'(i), 16'h0001);
        scen_array();
        scen_mbox();
        scen_sem();
        scen_conflict();
        results();
    end
endmodule : dpmx_host_test
`default_nettype wire
